/* include/ptt_pkg.sv */
// Package for the two-channel pulse-train output unit.
// Assumes a single 25 MHz clock shared by every user of these constants.
`default_nettype none
package ptt_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int FREQ_MIN_HZ = 6;
    localparam int FREQ_MAX_HZ = 100000;
    localparam int SEG_MAX = 40;
    localparam int SEG_WORDS = 4;
    localparam int SEG_W = 6;
    localparam int TBL_AW = 8;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [15:0] SEG_RESET = 16'h0000;
    localparam logic [31:0] HALF_DIV = 32'h0000_0002;

    typedef enum logic [1:0] {
        PTT_IDLE = 2'b00,
        PTT_ARC  = 2'b01,
        PTT_TBL  = 2'b10,
        PTT_DONE = 2'b11
    } ptt_state_t;
endpackage : ptt_pkg
`default_nettype wire

/* core/ptt_core.sv */
// Two-channel pulse and direction output: absolute arc mode, table mode.
// Assumes synchronous inputs and a host that keeps the table stable.
`default_nettype none
module ptt_core
    import ptt_pkg::*;
#(
    parameter int SEGS = SEG_MAX
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic arc_enable,
    input wire logic [31:0] x_target,
    input wire logic [31:0] y_target,
    input wire logic arc_rate_hz_valid,
    input wire logic [31:0] arc_rate_hz,
    input wire logic table_enable,
    input wire logic table_channel,
    input wire logic [15:0] table_seg_count,
    input wire logic table_cyclic_enable,
    input wire logic scan_strobe,
    input wire logic tbl_we,
    input wire logic [TBL_AW-1:0] tbl_addr,
    input wire logic [15:0] tbl_wdata,
    input wire logic chan0_pause_flag,
    input wire logic chan1_pause_flag,
    input wire logic done_clear,
    output logic x_pulse_out,
    output logic x_dir_out,
    output logic y_pulse_out,
    output logic y_dir_out,
    output logic chan0_done_flag,
    output logic chan1_done_flag,
    output logic [15:0] chan0_position_low,
    output logic [15:0] chan0_position_high,
    output logic [15:0] chan1_position_low,
    output logic [15:0] chan1_position_high,
    output logic [15:0] table_current_seg,
    output logic busy
);
    // The table and its index width are sized for at most SEG_MAX segments.
    if (SEGS < 1 || SEGS > SEG_MAX) begin : g_bad_segs
        $error("SEGS out of range");
    end

    // =========================================================
    // Reset release
    logic rs1_q, rs2_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire logic rst_sync_n = rs2_q;

    // =========================================================
    // Segment table, written by software outside a run.
    logic [15:0] tbl_mem [0:SEGS*SEG_WORDS-1];
    always_ff @(posedge clock) begin
        if (tbl_we && (32'(tbl_addr) < SEGS * SEG_WORDS)) begin
            tbl_mem[tbl_addr] <= tbl_wdata;
        end
    end

    // =========================================================
    // Control state
    ptt_state_t state_q;
    logic [31:0] pos0_q, pos1_q, tgt0_q, tgt1_q;
    logic [31:0] div_q, phase_q, left_q;
    logic [SEG_W-1:0] seg_q, nseg_q;
    logic chan_q, cyc_q, dir0_q, dir1_q, pul0_q, pul1_q;
    logic [15:0] cur_seg_q;
    logic [1:0] ld_q;
    logic done0_q, done1_q;

    wire logic pause0 = chan0_pause_flag;
    wire logic pause1 = chan1_pause_flag;
    // Table mode pauses only the channel it drives.
    wire logic tbl_pause = chan_q ? pause1 : pause0;
    wire logic arc_pause = pause0 | pause1;
    // Direction is a plain signed compare against present position.
    wire logic gt0 = $signed(x_target) > $signed(pos0_q);
    wire logic gt1 = $signed(y_target) > $signed(pos1_q);
    wire logic lt0 = $signed(x_target) < $signed(pos0_q);
    wire logic lt1 = $signed(y_target) < $signed(pos1_q);
    wire logic at0 = pos0_q == tgt0_q;
    wire logic at1 = pos1_q == tgt1_q;
    wire logic [31:0] arc_hz = arc_rate_hz_valid ? arc_rate_hz
                                                 : 32'(FREQ_MAX_HZ);
    wire logic [SEG_W+1:0] base = {seg_q, 2'b00};
    wire logic [31:0] f_word = {tbl_mem[base + 8'd1], tbl_mem[base]};
    wire logic [31:0] n_word = {tbl_mem[base + 8'd3],
                                tbl_mem[base + 8'd2]};
    wire logic [31:0] f_clip = (f_word < 32'(FREQ_MIN_HZ)) ?
        32'(FREQ_MIN_HZ) : (f_word > 32'(FREQ_MAX_HZ)) ?
        32'(FREQ_MAX_HZ) : f_word;
    wire logic [31:0] f_div = 32'(CLK_HZ) / (f_clip * HALF_DIV);
    wire logic [31:0] a_div = 32'(CLK_HZ) / (arc_hz * HALF_DIV);
    wire logic tick = phase_q + 32'd1 >= div_q;
    wire logic last_seg = seg_q + 6'd1 >= nseg_q;
    wire logic [SEG_W-1:0] cnt_clip = (table_seg_count == 16'h0000) ?
        6'h01 : (table_seg_count > 16'(SEGS)) ?
        SEG_W'(SEGS) : table_seg_count[SEG_W-1:0];

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= PTT_IDLE;
            pos0_q <= POS_RESET;
            pos1_q <= POS_RESET;
            tgt0_q <= POS_RESET;
            tgt1_q <= POS_RESET;
            div_q <= 32'h0000_0001;
            phase_q <= 32'h0000_0000;
            left_q <= 32'h0000_0000;
            seg_q <= 6'h00;
            nseg_q <= 6'h01;
            chan_q <= 1'b0;
            cyc_q <= 1'b0;
            dir0_q <= 1'b0;
            dir1_q <= 1'b0;
            pul0_q <= 1'b0;
            pul1_q <= 1'b0;
            cur_seg_q <= SEG_RESET;
            ld_q <= 2'b00;
            done0_q <= 1'b0;
            done1_q <= 1'b0;
        end else begin
            if (scan_strobe && state_q == PTT_TBL) begin
                cur_seg_q <= 16'(seg_q) + 16'h0001;
            end
            case (state_q)
            PTT_IDLE: begin
                pul0_q <= 1'b0;
                pul1_q <= 1'b0;
                phase_q <= 32'h0000_0000;
                if (done_clear) begin
                    done0_q <= 1'b0;
                    done1_q <= 1'b0;
                end
                // Arc wins when both start together, one op per line.
                if (arc_enable) begin
                    tgt0_q <= x_target;
                    tgt1_q <= y_target;
                    div_q <= (a_div == 0) ? 32'd1 : a_div;
                    dir0_q <= lt0 ? 1'b1 : gt0 ? 1'b0 : dir0_q;
                    dir1_q <= lt1 ? 1'b1 : gt1 ? 1'b0 : dir1_q;
                    state_q <= PTT_ARC;
                end else if (table_enable) begin
                    chan_q <= table_channel;
                    cyc_q <= table_cyclic_enable;
                    nseg_q <= cnt_clip;
                    seg_q <= 6'h00;
                    ld_q <= 2'b01;
                    state_q <= PTT_TBL;
                end
            end
            PTT_ARC: begin
                if (!arc_enable) begin
                    state_q <= PTT_IDLE;
                end else if (at0 && at1 && !pul0_q && !pul1_q) begin
                    done0_q <= 1'b1;
                    done1_q <= 1'b1;
                    state_q <= PTT_DONE;
                end else if (!arc_pause) begin
                    phase_q <= tick ? 32'h0 : phase_q + 32'd1;
                    if (tick) begin
                        // Step both axes together at the same rate.
                        if (pul0_q || !at0) pul0_q <= !pul0_q;
                        if (pul1_q || !at1) pul1_q <= !pul1_q;
                        if (!pul0_q && !at0) begin
                            pos0_q <= dir0_q ? pos0_q - 32'd1
                                             : pos0_q + 32'd1;
                        end
                        if (!pul1_q && !at1) begin
                            pos1_q <= dir1_q ? pos1_q - 32'd1
                                             : pos1_q + 32'd1;
                        end
                    end
                end
            end
            PTT_TBL: begin
                if (!table_enable) begin
                    state_q <= PTT_IDLE;
                end else if (ld_q != 2'b00) begin
                    div_q <= (f_div == 0) ? 32'd1 : f_div;
                    left_q <= n_word;
                    phase_q <= 32'h0;
                    ld_q <= 2'b00;
                end else if (left_q == 32'h0 && !pul0_q && !pul1_q) begin
                    if (!last_seg) begin
                        seg_q <= seg_q + 6'd1;
                        ld_q <= 2'b01;
                    end else if (cyc_q) begin
                        seg_q <= 6'h00;
                        ld_q <= 2'b01;
                    end else begin
                        if (chan_q) done1_q <= 1'b1;
                        else done0_q <= 1'b1;
                        state_q <= PTT_DONE;
                    end
                end else if (!tbl_pause) begin
                    phase_q <= tick ? 32'h0 : phase_q + 32'd1;
                    if (tick) begin
                        // Only the pulse line moves here.
                        if (chan_q) pul1_q <= !pul1_q;
                        else pul0_q <= !pul0_q;
                        if (!(chan_q ? pul1_q : pul0_q)) begin
                            left_q <= left_q - 32'd1;
                            if (chan_q) begin
                                pos1_q <= dir1_q ? pos1_q - 32'd1
                                                 : pos1_q + 32'd1;
                            end else begin
                                pos0_q <= dir0_q ? pos0_q - 32'd1
                                                 : pos0_q + 32'd1;
                            end
                        end
                    end
                end
            end
            default: begin
                // Done holds until both arc_enable and table_enable have dropped.
                if (!arc_enable && !table_enable) begin
                    if (done_clear) begin
                        done0_q <= 1'b0;
                        done1_q <= 1'b0;
                    end
                    state_q <= PTT_IDLE;
                end
            end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            x_pulse_out <= 1'b0;
            y_pulse_out <= 1'b0;
            x_dir_out <= 1'b0;
            y_dir_out <= 1'b0;
            chan0_done_flag <= 1'b0;
            chan1_done_flag <= 1'b0;
            chan0_position_low <= 16'h0000;
            chan0_position_high <= 16'h0000;
            chan1_position_low <= 16'h0000;
            chan1_position_high <= 16'h0000;
            table_current_seg <= SEG_RESET;
            busy <= 1'b0;
        end else begin
            x_pulse_out <= pul0_q;
            y_pulse_out <= pul1_q;
            x_dir_out <= dir0_q;
            y_dir_out <= dir1_q;
            chan0_done_flag <= done0_q;
            chan1_done_flag <= done1_q;
            chan0_position_low <= pos0_q[15:0];
            chan0_position_high <= pos0_q[31:16];
            chan1_position_low <= pos1_q[15:0];
            chan1_position_high <= pos1_q[31:16];
            table_current_seg <= cur_seg_q;
            busy <= (state_q == PTT_ARC) || (state_q == PTT_TBL);
        end
    end
endmodule : ptt_core
`default_nettype wire

/* sim/ptt_drive_model.sv */
// Drive-side model: counts steps on one pulse and direction pair.
// Assumes the pulse lines are synchronous to the core clock.
`default_nettype none
module ptt_drive_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pulse,
    input wire logic dir,
    output var logic [31:0] count,
    output var logic [15:0] hi_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q;
    // ====
    // Step counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b0;
            count <= 32'h0;
            hi_len <= 16'h0;
        end else begin
            last_q <= pulse;
            if (pulse && !last_q)
                count <= dir ? count - 32'h1 : count + 32'h1;
            if (pulse)
                hi_len <= last_q ? hi_len + 16'h1 : 16'h1;
        end
    end
endmodule : ptt_drive_model
`default_nettype wire

/* sim/ptt_core_assertions.sv */
// Checker for ptt_core: position, pause, direction and done behaviour.
// Assumes it is bound to ptt_core with the port names unchanged.
`default_nettype none
module ptt_core_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chan0_pause_flag,
    input wire logic chan1_pause_flag,
    input wire logic scan_strobe,
    input wire logic done_clear,
    input wire logic x_pulse_out,
    input wire logic x_dir_out,
    input wire logic y_pulse_out,
    input wire logic y_dir_out,
    input wire logic chan0_done_flag,
    input wire logic [15:0] chan0_position_low,
    input wire logic [15:0] chan0_position_high,
    input wire logic [15:0] chan1_position_low,
    input wire logic [15:0] chan1_position_high,
    input wire logic [15:0] table_current_seg,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [31:0] pos0 = {chan0_position_high, chan0_position_low};
    wire logic [31:0] pos1 = {chan1_position_high, chan1_position_low};
    // ====
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_paused;
        chan0_pause_flag && chan1_pause_flag;
    endsequence
    sequence s_long_busy;
        busy [*3];
    endsequence
    chk_pause_freeze: assert property (
        s_paused [*3] |-> $stable({x_pulse_out, y_pulse_out}))
        else $error("Pulse moved while paused.");
    chk_dir_hold: assert property (
        s_long_busy |-> $stable({x_dir_out, y_dir_out}))
        else $error("Direction changed in a run.");
    chk_x_up: assert property (
        $rose(x_pulse_out) && !x_dir_out |-> pos0 == $past(pos0) + 32'h1)
        else $error("X position did not rise.");
    chk_y_down: assert property (
        $rose(y_pulse_out) && y_dir_out |-> pos1 == $past(pos1) - 32'h1)
        else $error("Y position did not fall.");
    chk_pos_quiet: assert property (
        !$rose(x_pulse_out) && !$rose(y_pulse_out) |-> $stable({pos0, pos1}))
        else $error("Position moved without a pulse.");
    chk_idle_quiet: assert property (
        !busy && !$past(busy) |-> !$rose(x_pulse_out) && !$rose(y_pulse_out))
        else $error("Pulse started while idle.");
    chk_done_sticky: assert property (
        chan0_done_flag && !done_clear && !$past(done_clear)
        |=> chan0_done_flag)
        else $error("Done flag fell without a clear.");
    chk_seg_refresh: assert property (
        !$past(scan_strobe) && !$past(scan_strobe, 2)
        |-> $stable(table_current_seg))
        else $error("Segment index moved without a scan.");
endmodule : ptt_core_assertions
bind ptt_core ptt_core_assertions u_chk (.clock(clock), .rst_n(rst_n),
    .chan0_pause_flag(chan0_pause_flag), .chan1_pause_flag(chan1_pause_flag),
    .scan_strobe(scan_strobe), .done_clear(done_clear),
    .x_pulse_out(x_pulse_out), .x_dir_out(x_dir_out),
    .y_pulse_out(y_pulse_out), .y_dir_out(y_dir_out),
    .chan0_done_flag(chan0_done_flag), .busy(busy),
    .chan0_position_low(chan0_position_low),
    .chan0_position_high(chan0_position_high),
    .chan1_position_low(chan1_position_low),
    .chan1_position_high(chan1_position_high),
    .table_current_seg(table_current_seg));
`default_nettype wire

/* sim/tb_pulse_train_table_arc_output.sv */
// Testbench for ptt_core: arc moves, table runs, cyclic, pause and stop.
// Assumes the package, core, checker and drive model are compiled first.
`default_nettype none
module tb_pulse_train_table_arc_output;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, arc_enable, arc_rate_hz_valid, table_enable;
    logic table_channel, table_cyclic_enable, scan_strobe, tbl_we;
    logic chan0_pause_flag, chan1_pause_flag, done_clear, busy;
    logic [31:0] x_target, y_target, arc_rate_hz, cnt0, cnt1;
    logic [15:0] table_seg_count, tbl_wdata, hl0, hl1, table_current_seg;
    logic [ptt_pkg::TBL_AW-1:0] tbl_addr;
    logic x_pulse_out, x_dir_out, y_pulse_out, y_dir_out;
    logic chan0_done_flag, chan1_done_flag;
    logic [15:0] chan0_position_low, chan0_position_high;
    logic [15:0] chan1_position_low, chan1_position_high;
    int fails = 0, n_checks = 0;
    // ====
    // Design and drive models
    ptt_core u_dut (.clock, .rst_n, .arc_enable, .x_target, .y_target,
        .arc_rate_hz_valid, .arc_rate_hz, .table_enable, .table_channel,
        .table_seg_count, .table_cyclic_enable, .scan_strobe, .tbl_we,
        .tbl_addr, .tbl_wdata, .chan0_pause_flag, .chan1_pause_flag,
        .done_clear, .x_pulse_out, .x_dir_out, .y_pulse_out, .y_dir_out,
        .chan0_done_flag, .chan1_done_flag, .chan0_position_low,
        .chan0_position_high, .chan1_position_low, .chan1_position_high,
        .table_current_seg, .busy);
    ptt_drive_model u_drv0 (.clock, .rst_n, .pulse(x_pulse_out),
        .dir(x_dir_out), .count(cnt0), .hi_len(hl0));
    ptt_drive_model u_drv1 (.clock, .rst_n, .pulse(y_pulse_out),
        .dir(y_dir_out), .count(cnt1), .hi_len(hl1));
    always #20 clock = ~clock;
    // ====
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wait_done(input logic ch);
        for (int i = 0; i < 20000; i++) begin
            if ((ch ? chan1_done_flag : chan0_done_flag) === 1'b1)
                break;
            tick(1);
        end
    endtask : wait_done
    task automatic idle();
        arc_enable = 1'b0;
        table_enable = 1'b0;
        tick(2);
        done_clear = 1'b1;
        tick(1);
        done_clear = 1'b0;
        tick(1);
    endtask : idle
    task automatic scan_pulse();
        scan_strobe = 1'b1;
        tick(1);
        scan_strobe = 1'b0;
        tick(2);
    endtask : scan_pulse
    task automatic seg_wr(input int s, input logic [31:0] f, n);
        logic [63:0] w;
        w = {n, f};
        for (int k = 0; k < 4; k++) begin
            tbl_we = 1'b1;
            tbl_addr = ptt_pkg::TBL_AW'(4 * s + k);
            tbl_wdata = w[16 * k +: 16];
            tick(1);
        end
        tbl_we = 1'b0;
    endtask : seg_wr
    task automatic t_arc(input logic [31:0] x, y, r, input logic dx, dy);
        arc_rate_hz_valid = r != 0;
        arc_rate_hz = r;
        x_target = x;
        y_target = y;
        arc_enable = 1'b1;
        tick(300);
        x_target = 32'h0;
        wait_done(1'b0);
        chk("done0", 1, chan0_done_flag);
        chk("x count", x, cnt0);
        chk("y count", y, cnt1);
        chk("x pos", x, {chan0_position_high, chan0_position_low});
        chk("y pos", y, {chan1_position_high, chan1_position_low});
        chk("dirs", {dx, dy}, {x_dir_out, y_dir_out});
        idle();
    endtask : t_arc
    task automatic t_table();
        logic [31:0] c, c0;
        logic d;
        seg_wr(0, 100000, 2);
        seg_wr(1, 50000, 1);
        table_channel = 1'b1;
        table_seg_count = 16'h2;
        c = cnt1;
        c0 = cnt0;
        d = y_dir_out;
        table_enable = 1'b1;
        tick(3);
        table_seg_count = 16'h1;
        // The index is only seen while a segment runs, so sample mid-segment.
        tick(200);
        scan_pulse();
        chk("segment", 1, table_current_seg);
        tick(500);
        scan_pulse();
        chk("segment", 2, table_current_seg);
        wait_done(1'b1);
        chk("done1", 1, chan1_done_flag);
        chk("pulses", d ? c - 32'h3 : c + 32'h3, cnt1);
        chk("y dir", d, y_dir_out);
        chk("x quiet", c0, cnt0);
        chk("half", ptt_pkg::CLK_HZ / 100000, hl1);
    endtask : t_table
    task automatic t_cyc();
        logic [31:0] c;
        seg_wr(0, 100000, 2);
        table_channel = 1'b0;
        table_seg_count = 16'h1;
        table_cyclic_enable = 1'b1;
        c = cnt0;
        table_enable = 1'b1;
        tick(1500);
        c = x_dir_out ? c - cnt0 : cnt0 - c;
        chk("cyclic", 1, c >= 5);
        {chan0_pause_flag, chan1_pause_flag} = 2'h3;
        tick(3);
        c = cnt0;
        tick(600);
        chk("paused", c, cnt0);
        {chan0_pause_flag, chan1_pause_flag} = 2'h0;
        tick(600);
        chk("resumed", 1, cnt0 != c);
        table_enable = 1'b0;
        tick(3);
        c = cnt0;
        tick(600);
        chk("stopped", c, cnt0);
        chk("busy", 0, busy);
    endtask : t_cyc
    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // ====
    // Main sequence and watchdog
    initial begin
        {arc_enable, arc_rate_hz_valid, table_enable, table_channel,
            table_cyclic_enable, scan_strobe, tbl_we, chan0_pause_flag,
            chan1_pause_flag, done_clear, x_target, y_target, arc_rate_hz,
            table_seg_count, tbl_wdata, tbl_addr} = '0;
        clock = 1'b0;
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(3);
        t_arc(5, -3, 0, 1'b0, 1'b1);
        // Both starts together: the arc must win and the table stay idle.
        table_enable = 1'b1;
        t_arc(2, -6, 50000, 1'b1, 1'b1);
        chk("x half", ptt_pkg::CLK_HZ / 100000, hl0);
        t_table();
        idle();
        t_cyc();
        report_and_stop();
    end
    initial begin
        #(40 * 40000);
        fails++;
        report_and_stop();
    end
endmodule : tb_pulse_train_table_arc_output
`default_nettype wire
